// ---- rtl/hw_config_bank.sv ----
// Purpose: upper hardware configuration register with APB access, detach control and interrupt
// Assumes: soft_reset is a synchronous non-power-on reset pulse; presetn is power-on reset
// Notes:   one wait-free APB access; pready is high in every access phase
`timescale 1ns/1ps
`default_nettype none
`include "hw_config_defines.svh"
module hw_config_bank #(
  parameter bit NEW_VARIANT  = 1'b1,
  parameter int LED_SLOW_CYC = `HWC_LED_SLOW_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`HWC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire logic                   soft_reset,
  input  wire logic                   eeprom_present,
  input  wire logic                   phy_link_up,
  input  wire logic                   wake_gpio,
  input  wire logic                   bulk_in_token,
  input  wire logic                   rx_fifo_empty,
  input  wire logic                   activity,
  output var  logic                   usb_attached,
  output var  logic                   descriptor_from_ram,
  output var  hw_config_pkg::boost_t  hs_drive_boost,
  output var  logic                   reply_zlp,
  output var  logic                   reply_nak,
  output var  logic                   activity_led,
  output var  logic                   irq
);
  import hw_config_pkg::*;

  logic                 desc_sel_ff;
  logic                 shield_ff;
  boost_t               boost_ff;
  logic                 reply_nak_sel_ff;
  logic                 led_fast_ff;
  logic                 detach_flag_ff;
  logic                 detach_req_ff;
  logic [`HWC_IRQ_W-1:0] irq_sts_ff;
  logic [`HWC_IRQ_W-1:0] irq_en_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic [31:0]          prdata_ff;
  logic                 desc_ram_ff;
  boost_t               boost_out_ff;
  logic                 zlp_ff;
  logic                 nak_ff;
  logic                 irq_ff;
  logic                 attached;
  logic                 reattach;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire setup      = psel & ~penable;
  wire access     = psel & penable & pready_ff;
  wire hit_cfg    = (paddr == `HWC_OFF_CONFIG);
  wire hit_sts    = (paddr == `HWC_OFF_IRQ_STATUS);
  wire hit_clr    = (paddr == `HWC_OFF_IRQ_CLEAR);
  wire hit_en     = (paddr == `HWC_OFF_IRQ_ENABLE);
  wire mapped     = hit_cfg | hit_sts | hit_clr | hit_en;
  wire wr         = access & pwrite;
  wire cfg_we     = wr & hit_cfg;
  wire new_we     = cfg_we & NEW_VARIANT;
  wire flag_clear = new_we & pwdata[`HWC_BIT_FLAG];
  wire detach_go  = new_we & pwdata[`HWC_BIT_DETACH] & attached;
  wire shield_rst = soft_reset & ~shield_ff;

  wire [31:0] cfg_word = {13'h0000, detach_flag_ff, detach_req_ff, desc_sel_ff, shield_ff,
                          boost_ff, reply_nak_sel_ff, led_fast_ff, 11'h000};
  wire [31:0] rd_word  = hit_cfg ? cfg_word :
                         hit_sts ? {30'h00000000, irq_sts_ff} :
                         hit_en  ? {30'h00000000, irq_en_ff} : 32'h00000000;
  wire [`HWC_IRQ_W-1:0] irq_events = {reattach, detach_req_ff};
  wire [`HWC_IRQ_W-1:0] irq_clr    = (wr & hit_clr) ? pwdata[`HWC_IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= setup ? rd_word : prdata_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protected fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_sel_ff <= `HWC_RST_DESC;
      shield_ff   <= `HWC_RST_SHIELD;
      boost_ff    <= `HWC_RST_BOOST;
    end else if (shield_rst) begin
      desc_sel_ff <= `HWC_RST_DESC;
      shield_ff   <= `HWC_RST_SHIELD;
      boost_ff    <= `HWC_RST_BOOST;
    end else if (new_we) begin
      desc_sel_ff <= pwdata[`HWC_BIT_DESC];
      shield_ff   <= pwdata[`HWC_BIT_SHIELD];
      boost_ff    <= pwdata[`HWC_BIT_BOOST_HI:`HWC_BIT_BOOST_LO];
    end
  end

  // unprotected fields follow every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_nak_sel_ff <= `HWC_RST_REPLY;
      led_fast_ff      <= `HWC_RST_LED;
    end else if (soft_reset) begin
      reply_nak_sel_ff <= `HWC_RST_REPLY;
      led_fast_ff      <= `HWC_RST_LED;
    end else if (cfg_we) begin
      reply_nak_sel_ff <= pwdata[`HWC_BIT_REPLY];
      led_fast_ff      <= pwdata[`HWC_BIT_LED];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detach request self-clears after one cycle; flag set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detach_req_ff  <= 1'b0;
      detach_flag_ff <= 1'b0;
    end else begin
      detach_req_ff  <= detach_go;
      detach_flag_ff <= reattach | (detach_flag_ff & ~flag_clear);
    end
  end

  usb_detach_ctrl u_detach (
    .pclk            (pclk),
    .presetn         (presetn),
    .detach_req      (detach_req_ff),
    .phy_link_up     (phy_link_up),
    .wake_gpio       (wake_gpio),
    .usb_attached_ff (attached),
    .reattach_ff     (reattach)
  );

  activity_led_stretch #(
    .SLOW_CYC (LED_SLOW_CYC),
    .FAST_CYC (`HWC_LED_FAST_CYC),
    .CNT_W    (`HWC_LED_CNT_W)
  ) u_led (
    .pclk      (pclk),
    .presetn   (presetn),
    .activity  (activity),
    .fast      (led_fast_ff),
    .led_on_ff (activity_led)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and level output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff <= '0;
      irq_en_ff  <= '0;
      irq_ff     <= 1'b0;
    end else begin
      irq_sts_ff <= irq_events | (irq_sts_ff & ~irq_clr);
      irq_en_ff  <= (wr & hit_en) ? pwdata[`HWC_IRQ_W-1:0] : irq_en_ff;
      irq_ff     <= |((irq_events | (irq_sts_ff & ~irq_clr)) & irq_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_ram_ff  <= 1'b0;
      boost_out_ff <= `HWC_RST_BOOST;
      zlp_ff       <= 1'b0;
      nak_ff       <= 1'b0;
    end else begin
      desc_ram_ff  <= ~eeprom_present & desc_sel_ff;
      boost_out_ff <= boost_ff;
      zlp_ff       <= bulk_in_token & rx_fifo_empty & ~reply_nak_sel_ff;
      nak_ff       <= bulk_in_token & rx_fifo_empty & reply_nak_sel_ff;
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign usb_attached        = attached;
  assign descriptor_from_ram = desc_ram_ff;
  assign hs_drive_boost      = boost_out_ff;
  assign reply_zlp           = zlp_ff;
  assign reply_nak           = nak_ff;
  assign irq                 = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_detach_write;
    cfg_we && NEW_VARIANT && pwdata[`HWC_BIT_DETACH] && usb_attached;
  endsequence
  sequence s_detach_done;
    detach_req_ff ##1 (!detach_req_ff && !usb_attached);
  endsequence

  a_detach_drops_bus: assert property (s_detach_write |=> s_detach_done)
    else $error("detach request did not drop the device off the bus");
  // flag follows the registered reattach pulse, one edge after the bus returns
  a_reattach_sets_flag: assert property ($rose(usb_attached) |=> detach_flag_ff)
    else $error("reattach without detach flag");
  a_flag_write_clear: assert property ((flag_clear && !reattach) |=> !detach_flag_ff)
    else $error("detach flag not cleared by write");
  a_flag_set_wins: assert property ((flag_clear && reattach) |=> detach_flag_ff)
    else $error("clear beat a reattach event");
  a_desc_ram_sel: assert property ((!eeprom_present && desc_sel_ff) |=> descriptor_from_ram)
    else $error("descriptor RAM not selected");
  a_desc_eeprom_wins: assert property (eeprom_present |=> !descriptor_from_ram)
    else $error("descriptor source acted with EEPROM present");
  a_shield_keeps: assert property ((soft_reset && shield_ff && !new_we) |=>
    ($stable(boost_ff) && $stable(desc_sel_ff) && shield_ff))
    else $error("shielded fields lost on soft reset");
  a_boost_follows: assert property (hs_drive_boost == $past(boost_ff))
    else $error("drive boost output mismatch");
  a_empty_reply: assert property ((bulk_in_token && rx_fifo_empty) |=>
    (reply_nak == $past(reply_nak_sel_ff) && reply_zlp != reply_nak))
    else $error("wrong reply to bulk IN on empty fifo");
  a_reserved_zero: assert property ((setup && hit_cfg) |=> prdata[31:19] == 13'h0000)
    else $error("reserved bits read nonzero");
endmodule : hw_config_bank
`default_nettype wire

// ---- rtl/hw_config_defines.svh ----
// Purpose: offsets, field positions, reset values and timing counts for the hardware configuration bank
// Assumes: 32-bit APB data, byte addresses, pclk at 100 MHz
// Notes:   included by the bank top, the LED stretcher and the bench; the detach controller and the package do not include it
`ifndef HW_CONFIG_DEFINES_SVH
`define HW_CONFIG_DEFINES_SVH

`define HWC_ADDR_W          12
`define HWC_OFF_CONFIG      12'h014
`define HWC_OFF_IRQ_STATUS  12'h018
`define HWC_OFF_IRQ_CLEAR   12'h01C
`define HWC_OFF_IRQ_ENABLE  12'h020

`define HWC_BIT_FLAG        18
`define HWC_BIT_DETACH      17
`define HWC_BIT_DESC        16
`define HWC_BIT_SHIELD      15
`define HWC_BIT_BOOST_HI    14
`define HWC_BIT_BOOST_LO    13
`define HWC_BIT_REPLY       12
`define HWC_BIT_LED         11

`define HWC_IRQ_W           2
`define HWC_IRQ_DETACH      0
`define HWC_IRQ_REATTACH    1

`define HWC_RST_DESC        1'b0
`define HWC_RST_SHIELD      1'b0
`define HWC_RST_BOOST       2'h0
`define HWC_RST_REPLY       1'b0
`define HWC_RST_LED         1'b0

`define HWC_CLK_PERIOD_NS   10
`define HWC_LED_SLOW_NS     80000000
`define HWC_LED_FAST_NS     15000
`define HWC_LED_SLOW_CYC    (`HWC_LED_SLOW_NS / `HWC_CLK_PERIOD_NS)
`define HWC_LED_FAST_CYC    (`HWC_LED_FAST_NS / `HWC_CLK_PERIOD_NS)
`define HWC_LED_CNT_W       24

`endif

// ---- rtl/hw_config_pkg.sv ----
// Purpose: types shared by the hardware configuration bank
// Assumes: nothing
// Notes:   numbers live in hw_config_defines.svh
package hw_config_pkg;
  typedef enum logic {DET_ATTACHED, DET_DETACHED} detach_state_t;
  typedef enum logic [1:0] {LED_IDLE, LED_ON, LED_OFF} led_state_t;
  typedef logic [1:0] boost_t;
endpackage : hw_config_pkg

// ---- rtl/usb_detach_ctrl.sv ----
// Purpose: keeps the device off the USB bus between a detach request and a wake condition
// Assumes: inputs synchronous to pclk
// Notes:   link wake is taken on a rising edge so a link already up does not undo the detach
`timescale 1ns/1ps
`default_nettype none
module usb_detach_ctrl (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic detach_req,
  input  wire logic phy_link_up,
  input  wire logic wake_gpio,
  output var  logic usb_attached_ff,
  output var  logic reattach_ff
);
  import hw_config_pkg::*;

  detach_state_t state_ff;
  detach_state_t nxt_state;
  logic          link_prev_ff;
  wire           link_rise = phy_link_up & ~link_prev_ff;
  wire           wake      = link_rise | wake_gpio;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DET_ATTACHED: if (detach_req) nxt_state = DET_DETACHED;
      DET_DETACHED: if (wake) nxt_state = DET_ATTACHED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff        <= DET_ATTACHED;
      link_prev_ff    <= 1'b0;
      usb_attached_ff <= 1'b1;
      reattach_ff     <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      link_prev_ff    <= phy_link_up;
      usb_attached_ff <= (nxt_state == DET_ATTACHED);
      reattach_ff     <= (state_ff == DET_DETACHED) & wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_detach_stays_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == DET_DETACHED && !wake) |=> !usb_attached_ff)
    else $error("device reattached without a wake condition");
  a_wake_reattaches: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == DET_DETACHED && wake) |=> (usb_attached_ff && reattach_ff))
    else $error("wake did not reattach the device");
endmodule : usb_detach_ctrl
`default_nettype wire

// ---- rtl/activity_led_stretch.sv ----
// Purpose: stretches activity pulses into visible LED on and off periods
// Assumes: activity is a pulse synchronous to pclk
// Notes:   period chosen at the start of each phase; changing speed mid-phase takes effect next phase
`timescale 1ns/1ps
`default_nettype none
`include "hw_config_defines.svh"
module activity_led_stretch #(
  parameter int SLOW_CYC = `HWC_LED_SLOW_CYC,
  parameter int FAST_CYC = `HWC_LED_FAST_CYC,
  parameter int CNT_W    = `HWC_LED_CNT_W
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic activity,
  input  wire logic fast,
  output var  logic led_on_ff
);
  import hw_config_pkg::*;

  led_state_t       state_ff;
  led_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  wire  [CNT_W-1:0] period_m1 = fast ? CNT_W'(FAST_CYC - 1) : CNT_W'(SLOW_CYC - 1);
  wire              cnt_done  = (cnt_ff == '0);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      LED_IDLE: if (activity) begin
        nxt_state = LED_ON;
        nxt_cnt   = period_m1;
      end
      LED_ON: if (cnt_done) begin
        nxt_state = LED_OFF;
        nxt_cnt   = period_m1;
      end else nxt_cnt = cnt_ff - CNT_W'(1);
      LED_OFF: if (cnt_done) nxt_state = LED_IDLE;
               else nxt_cnt = cnt_ff - CNT_W'(1);
      default: nxt_state = LED_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= LED_IDLE;
      cnt_ff    <= '0;
      led_on_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      led_on_ff <= (nxt_state == LED_ON);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  localparam int FAST_M1 = FAST_CYC - 1;
  a_led_fast_load: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == LED_IDLE && activity && fast) |=> (led_on_ff && cnt_ff == CNT_W'(FAST_M1)))
    else $error("fast LED period not loaded");
endmodule : activity_led_stretch
`default_nettype wire

// ---- bench/usb_host_model.sv ----
// Purpose: upstream host and link environment of the configuration bank
// Assumes: a reply arrives within three cycles of a token
// Notes:   polls only an attached device, as a real host would
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic pclk,
  input  wire logic usb_attached,
  input  wire logic reply_zlp,
  input  wire logic reply_nak,
  output var  logic bulk_in_token,
  output var  logic rx_fifo_empty,
  output var  logic phy_link_up,
  output var  logic wake_gpio
);
  initial begin
    bulk_in_token = 1'b0;
    rx_fifo_empty = 1'b1;
    phy_link_up   = 1'b0;
    wake_gpio     = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // token, collect reply
  task automatic in_token(input logic empty, output logic [1:0] rep);
    rep = 2'h0;
    if (usb_attached === 1'b1) begin
      @(posedge pclk);
      bulk_in_token <= 1'b1;
      rx_fifo_empty <= empty;
      @(posedge pclk);
      bulk_in_token <= 1'b0;
      repeat (3) begin
        @(posedge pclk);
        rep = rep | {reply_nak, reply_zlp};
      end
    end
  endtask : in_token
  task automatic set_wake(input logic link, input logic pin);
    @(posedge pclk);
    phy_link_up <= link;
    wake_gpio   <= pin;
  endtask : set_wake
endmodule : usb_host_model
`default_nettype wire

// ---- bench/usb_ethernet_hw_config_upper_tb.sv ----
// Purpose: self-checking bench of the upper hardware configuration bank
// Assumes: LED slow period shortened to 50 cycles
// Notes:   led length allows one cycle of slack, the period itself is exact in cycles
`timescale 1ns/1ps
`default_nettype none
`include "hw_config_defines.svh"
module usb_ethernet_hw_config_upper_tb;
  import hw_config_pkg::*;
  localparam int SLOW = 50;
  typedef struct {logic [31:0] wd; logic [31:0] rd; boost_t b; logic ram;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, soft_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        eeprom_present, phy_link_up, wake_gpio, bulk_in_token, rx_fifo_empty, activity;
  logic        usb_attached, descriptor_from_ram, reply_zlp, reply_nak, activity_led, irq, e;
  logic [31:0] prdata_old, qo;
  logic        att_old;
  logic [1:0]  rep;
  boost_t      hs_drive_boost;
  int          n_mismatch, checks;
  row_t        rows [4];
  hw_config_bank #(.NEW_VARIANT(1'b1), .LED_SLOW_CYC(SLOW)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_reset(soft_reset), .eeprom_present(eeprom_present), .phy_link_up(phy_link_up),
    .wake_gpio(wake_gpio), .bulk_in_token(bulk_in_token), .rx_fifo_empty(rx_fifo_empty),
    .activity(activity), .usb_attached(usb_attached), .descriptor_from_ram(descriptor_from_ram),
    .hs_drive_boost(hs_drive_boost), .reply_zlp(reply_zlp), .reply_nak(reply_nak),
    .activity_led(activity_led), .irq(irq));
  // older variant on the same bus: only bits 12:11 exist there
  hw_config_bank #(.NEW_VARIANT(1'b0), .LED_SLOW_CYC(SLOW)) dut_old (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_old), .pready(), .pslverr(),
    .soft_reset(soft_reset), .eeprom_present(eeprom_present), .phy_link_up(phy_link_up),
    .wake_gpio(wake_gpio), .bulk_in_token(bulk_in_token), .rx_fifo_empty(rx_fifo_empty),
    .activity(activity), .usb_attached(att_old), .descriptor_from_ram(), .hs_drive_boost(),
    .reply_zlp(), .reply_nak(), .activity_led(), .irq());
  usb_host_model host (
    .pclk(pclk), .usb_attached(usb_attached), .reply_zlp(reply_zlp), .reply_nak(reply_nak),
    .bulk_in_token(bulk_in_token), .rx_fifo_empty(rx_fifo_empty),
    .phy_link_up(phy_link_up), .wake_gpio(wake_gpio));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      n_mismatch++;
    end
  endtask : chk
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    qo = prdata_old;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, n >= 50}, 32'h0);
    if (n >= 50) complete_run();
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic wait_att(input logic v);
    int n;
    n = 0;
    while (usb_attached !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, usb_attached}, {31'h0, v});
    if (n >= 200) complete_run();
  endtask : wait_att
  task automatic led_len(input logic f, input int p);
    int n;
    wr(`HWC_OFF_CONFIG, f ? 32'h0000_0800 : 32'h0);
    @(posedge pclk);
    activity <= 1'b1;
    @(posedge pclk);
    activity <= 1'b0;
    n = 0;
    while (activity_led !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (activity_led === 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= p - 1 && n <= p + 1}, 32'h1);
    repeat (p + 5) @(posedge pclk);
  endtask : led_len
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, soft_reset, eeprom_present, activity} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    // boost and descriptor rows; reserved bits never stick
    rows = '{'{32'h0001_F800, 32'h0001_F800, 2'h3, 1'b1}, '{32'h0000_2000, 32'h0000_2000, 2'h1, 1'b0},
             '{32'h0001_4000, 32'h0001_4000, 2'h2, 1'b1}, '{32'hFFF8_07FF, 32'h0000_0000, 2'h0, 1'b0}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`HWC_OFF_CONFIG, 32'h0);
    rd(`HWC_OFF_IRQ_STATUS, 32'h0);
    chk({30'h0, usb_attached, irq}, 32'h2);
    foreach (rows[i]) begin
      wr(`HWC_OFF_CONFIG, rows[i].wd);
      rd(`HWC_OFF_CONFIG, rows[i].rd);
      chk(qo, rows[i].wd & 32'h0000_1800);
      chk({30'h0, hs_drive_boost}, {30'h0, rows[i].b});
      chk({31'h0, descriptor_from_ram}, {31'h0, rows[i].ram});
    end
    wr(`HWC_OFF_CONFIG, 32'h0001_0000);
    eeprom_present <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, descriptor_from_ram}, 32'h0);
    eeprom_present <= 1'b0;
    wr(`HWC_OFF_CONFIG, 32'h0001_F800);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(`HWC_OFF_CONFIG, 32'h0001_E000);
    wr(`HWC_OFF_CONFIG, 32'h0001_6800);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(`HWC_OFF_CONFIG, 32'h0);
    host.in_token(1'b1, rep);
    chk({30'h0, rep}, 32'h1);
    wr(`HWC_OFF_CONFIG, 32'h0000_1000);
    host.in_token(1'b1, rep);
    chk({30'h0, rep}, 32'h2);
    host.in_token(1'b0, rep);
    chk({30'h0, rep}, 32'h0);
    wr(`HWC_OFF_CONFIG, 32'h0);
    wr(`HWC_OFF_IRQ_ENABLE, 32'h1);
    wr(`HWC_OFF_CONFIG, 32'h0002_0000);
    wait_att(1'b0);
    chk({31'h0, att_old}, 32'h1);
    rd(`HWC_OFF_CONFIG, 32'h0);
    repeat (20) @(posedge pclk);
    chk({30'h0, usb_attached, irq}, 32'h1);
    rd(`HWC_OFF_IRQ_STATUS, 32'h1);
    wr(`HWC_OFF_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    host.set_wake(1'b1, 1'b0);
    wait_att(1'b1);
    rd(`HWC_OFF_CONFIG, 32'h0004_0000);
    rd(`HWC_OFF_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`HWC_OFF_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`HWC_OFF_CONFIG, 32'h0004_0000);
    rd(`HWC_OFF_CONFIG, 32'h0);
    wr(`HWC_OFF_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // pin wake while link stays up
    wr(`HWC_OFF_CONFIG, 32'h0002_0000);
    wait_att(1'b0);
    // wake and a flag clear land on the same edge: the set must win
    fork
      host.set_wake(1'b1, 1'b1);
      wr(`HWC_OFF_CONFIG, 32'h0004_0000);
    join
    wait_att(1'b1);
    host.set_wake(1'b0, 1'b0);
    rd(`HWC_OFF_CONFIG, 32'h0004_0000);
    rd(`HWC_OFF_IRQ_CLEAR, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    led_len(1'b0, SLOW);
    led_len(1'b1, `HWC_LED_FAST_CYC);
    wr(`HWC_OFF_CONFIG, 32'h0001_F800);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`HWC_OFF_CONFIG, 32'h0);
    complete_run();
  end
endmodule : usb_ethernet_hw_config_upper_tb
`default_nettype wire
